/* File: ffc_div.sv */
// Pixel divide stage with saturation and bypass
`default_nettype none

module ffc_div #(
    parameter int PIX_W = ffc_pkg::FFC_PIX_W
) (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic ce, // Clock enable
    input wire logic en, // Advance enable
    input wire logic in_valid, // Input word valid
    input wire logic in_sof, // First pixel of frame
    input wire logic [PIX_W-1:0] in_level, // Original level
    input wire logic [PIX_W-1:0] in_map, // Interpolated map level
    input wire logic [PIX_W-1:0] in_ref, // Reference scale
    input wire logic in_bypass, // Pass pixel unchanged
    output logic out_valid, // Result valid
    output logic out_sof, // First pixel of frame
    output logic [PIX_W-1:0] out_level // Corrected level
);
    import ffc_pkg::*;

    localparam logic [PIX_W-1:0] MAX_LVL = '1;

    logic [2*PIX_W-1:0] prod;
    logic [2*PIX_W-1:0] quot;
    logic [PIX_W-1:0] result;

    always_comb
    begin
        prod = (2*PIX_W)'(in_level) * (2*PIX_W)'(in_ref);
        quot = '0;
        if (in_bypass)
        begin
            result = in_level;
        end
        else if (in_map == '0)
        begin
            result = MAX_LVL;
        end
        else
        begin
            quot = prod / (2*PIX_W)'(in_map);
            result = (quot > (2*PIX_W)'(MAX_LVL)) ? MAX_LVL : quot[PIX_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            out_valid <= 1'b0;
            out_sof <= 1'b0;
            out_level <= '0;
        end
        else if (ce && en)
        begin
            out_valid <= in_valid;
            out_sof <= in_sof;
            out_level <= result;
        end
    end

endmodule : ffc_div

`default_nettype wire

/* File: ffc_fifo.sv */
// Small first-in first-out buffer on flip-flops
`default_nettype none

module ffc_fifo #(
    parameter int W = 13,
    parameter int DEPTH = ffc_pkg::FFC_FIFO_DEPTH,
    parameter int LVL_W = $clog2(DEPTH + 1)
) (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic ce, // Clock enable
    input wire logic in_valid, // Write request
    output logic in_ready, // Room for one word
    input wire logic [W-1:0] in_data, // Write word
    output logic out_valid, // Word available
    input wire logic out_ready, // Read acknowledge
    output logic [W-1:0] out_data, // Head word
    output logic [LVL_W-1:0] level // Words held
);
    import ffc_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [LVL_W-1:0] level_reg;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + AW'(1));
    endfunction : ptr_inc

    assign in_ready = (level_reg != LVL_W'(DEPTH));
    assign out_valid = (level_reg != '0);
    assign out_data = mem_reg[rptr_reg];
    assign level = level_reg;
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem_reg[wptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            level_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wptr_reg <= ptr_inc(wptr_reg);
            end
            if (pop)
            begin
                rptr_reg <= ptr_inc(rptr_reg);
            end
            if (push && !pop)
            begin
                level_reg <= LVL_W'(level_reg + LVL_W'(1));
            end
            else if (pop && !push)
            begin
                level_reg <= LVL_W'(level_reg - LVL_W'(1));
            end
        end
    end

endmodule : ffc_fifo

`default_nettype wire

/* File: ffc_pix_partner.sv */
// Pixel source and sink with periodic stalls
`default_nettype none

module ffc_pix_partner (
    input wire logic clk_sys, // Clock
    input wire logic go, // Start frame
    input wire logic [11:0] base, // First level
    input wire logic [12:0] count, // Pixels
    output logic pix_in_valid, // Offered
    input wire logic pix_in_ready, // Taken
    output logic pix_in_sof, // Frame start
    output logic [11:0] original_level, // Level
    output logic pix_out_ready // Sink ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] sent = 13'h0;
    logic [1:0] tick = 2'h0;
    initial
    begin
        pix_in_valid = 1'b0;
        pix_in_sof = 1'b0;
        original_level = 12'h0;
        pix_out_ready = 1'b0;
    end
    always @(posedge clk_sys)
    begin
        tick <= tick + 2'h1;
        pix_out_ready <= tick != 2'h3; // Sink stalls one cycle in four
        if (go && !pix_in_valid)
        begin
            sent <= 13'h0;
            pix_in_valid <= 1'b1;
            pix_in_sof <= 1'b1;
            original_level <= base;
        end
        else if (pix_in_valid && pix_in_ready)
        begin
            sent <= sent + 13'h1;
            pix_in_sof <= 1'b0;
            original_level <= base + {9'h0, sent[2:0] + 3'h1};
            if (sent + 13'h1 == count)
            begin
                pix_in_valid <= 1'b0;
                original_level <= ~original_level; // Released lines invert
            end
        end
    end
endmodule : ffc_pix_partner

`default_nettype wire

/* File: ffc_pkg.sv */
// Shared constants and state type of the flat field correction unit
`default_nettype none

package ffc_pkg;

    // Default geometry and datapath sizes
    localparam int FFC_PIX_W = 12;
    localparam int FFC_MAP_W = 8;
    localparam int FFC_MAP_H = 8;
    localparam int FFC_STEP_LOG = 3;
    localparam int FFC_FIFO_DEPTH = 4;
    localparam int FFC_SLOTS = 16;
    localparam int FFC_SLOT_W = 4;
    localparam int FFC_ADDR_W = 8;
    localparam int FFC_DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] FFC_OFS_CTRL = 8'h00;
    localparam logic [7:0] FFC_OFS_CMD = 8'h04;
    localparam logic [7:0] FFC_OFS_SLOT = 8'h08;
    localparam logic [7:0] FFC_OFS_BOOT = 8'h0c;
    localparam logic [7:0] FFC_OFS_REF = 8'h10;
    localparam logic [7:0] FFC_OFS_STAT = 8'h14;

    // Field positions
    localparam int FFC_CTRL_EN_BIT = 0;
    localparam int FFC_CMD_GEN_BIT = 0;
    localparam int FFC_CMD_STORE_BIT = 1;
    localparam int FFC_CMD_RECALL_BIT = 2;
    localparam int FFC_STAT_BUSY_BIT = 0;
    localparam int FFC_STAT_STATE_LSB = 1;
    localparam int FFC_STAT_MAPOK_BIT = 4;

    // Reset values
    localparam logic FFC_EN_RST = 1'b0;
    localparam logic [3:0] FFC_SLOT_RST = 4'h0;
    localparam logic [3:0] FFC_BOOT_RST = 4'h0;
    localparam int FFC_REF_RST = 2048;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b000,
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_STORE = 3'b011,
        ST_GWAIT = 3'b100,
        ST_GRUN = 3'b101
    } ffc_state_t;

endpackage : ffc_pkg

`default_nettype wire

/* File: ffc_top.sv */
// Flat field correction unit: map management, interpolation and pixel path
// Functional notes
// - Corrected level is original level times the reference level, divided by the local map level.
// - Generate builds the reduced map from the next frame.
// - Generated map lives only in working storage, lost on reset.
// - Sixteen retained slots, selected by a value zero to fifteen.
// - Store copies the working map over the selected slot.
// - Recall copies the selected slot into working storage.
// - Reduced map is enlarged by bilinear interpolation before dividing.
// - Correction applies only while enabled; otherwise pixels pass unchanged.
// - Boot copies the slot named by the boot slot setting, which reset sets to slot zero.
`default_nettype none

module ffc_top #(
    parameter int PIX_W = ffc_pkg::FFC_PIX_W,
    parameter int MAP_W = ffc_pkg::FFC_MAP_W,
    parameter int MAP_H = ffc_pkg::FFC_MAP_H,
    parameter int STEP_LOG = ffc_pkg::FFC_STEP_LOG,
    parameter int FIFO_DEPTH = ffc_pkg::FFC_FIFO_DEPTH
) (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic ce, // Clock enable
    input wire logic [ffc_pkg::FFC_ADDR_W-1:0] reg_addr, // Register byte address
    input wire logic [ffc_pkg::FFC_DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [ffc_pkg::FFC_DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
    input wire logic pix_in_valid, // Input pixel valid
    output logic pix_in_ready, // Input pixel accepted
    input wire logic pix_in_sof, // First pixel of frame
    input wire logic [PIX_W-1:0] original_level, // Input pixel level
    output logic pix_out_valid, // Output pixel valid
    input wire logic pix_out_ready, // Output pixel taken
    output logic pix_out_sof, // First pixel of frame
    output logic [PIX_W-1:0] corrected_level // Output pixel level
);
    import ffc_pkg::*;

    localparam int STEP = 1 << STEP_LOG;
    localparam int IMG_W = MAP_W * STEP;
    localparam int IMG_H = MAP_H * STEP;
    localparam int MAP_N = MAP_W * MAP_H;
    localparam int IDX_W = $clog2(MAP_N);
    localparam int XW = $clog2(IMG_W);
    localparam int YW = $clog2(IMG_H);
    localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
    localparam int CNT_W = LVL_W + 2;
    localparam int DW = PIX_W + 1;

    // Control registers
    logic correction_enable_reg;
    logic [FFC_SLOT_W-1:0] map_slot_select_reg;
    logic [FFC_SLOT_W-1:0] boot_slot_select_reg;
    logic [PIX_W-1:0] ref_level_reg;
    logic [FFC_DATA_W-1:0] rdata_reg;
    logic [FFC_DATA_W-1:0] rdata_next;

    // Map storage and sequencer
    ffc_state_t state_reg;
    logic [FFC_SLOT_W-1:0] op_slot_reg;
    logic [FFC_SLOT_W-1:0] src_slot;
    logic [IDX_W-1:0] copy_idx_reg;
    logic copy_last;
    logic map_ok_reg;
    logic [PIX_W-1:0] work_map [MAP_N];
    logic [PIX_W-1:0] nv_map [FFC_SLOTS][MAP_N];

    // Command decode
    logic cmd_wr;
    logic map_generate_cmd;
    logic map_store_cmd;
    logic map_recall_cmd;

    // Pixel position and interpolation
    logic pix_in_ready_reg;
    logic acc;
    logic [XW-1:0] x_reg;
    logic [YW-1:0] y_reg;
    logic [XW-1:0] cur_x;
    logic [YW-1:0] cur_y;
    logic frame_last;
    logic on_grid;
    logic gen_wr;
    int cx;
    int cy;
    int cx1;
    int cy1;
    logic [PIX_W-1:0] row0;
    logic [PIX_W-1:0] row1;
    logic [PIX_W-1:0] interp;

    // Pipeline
    logic adv;
    logic s1_valid_reg;
    logic s1_sof_reg;
    logic [PIX_W-1:0] s1_level_reg;
    logic [PIX_W-1:0] s1_map_reg;
    logic s1_bypass_reg;
    logic div_valid;
    logic div_sof;
    logic [PIX_W-1:0] div_level;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [DW-1:0] fifo_out_data;
    logic [LVL_W-1:0] fifo_level;
    logic [CNT_W-1:0] occupancy;
    logic out_valid_reg;
    logic out_sof_reg;
    logic [PIX_W-1:0] out_level_reg;

    function automatic logic [IDX_W-1:0] map_idx(input int mx, input int my);
        return IDX_W'(my * MAP_W + mx);
    endfunction : map_idx

    function automatic logic [PIX_W-1:0] lerp(input logic [PIX_W-1:0] a, input logic [PIX_W-1:0] b,
                                              input logic [STEP_LOG-1:0] f);
        logic [PIX_W+STEP_LOG-1:0] t;
        t = (PIX_W+STEP_LOG)'(a) * (PIX_W+STEP_LOG)'(STEP - int'(f))
            + (PIX_W+STEP_LOG)'(b) * (PIX_W+STEP_LOG)'(f);
        return t[PIX_W+STEP_LOG-1:STEP_LOG];
    endfunction : lerp

    assign reg_rdata = rdata_reg;
    assign pix_in_ready = pix_in_ready_reg;
    assign pix_out_valid = out_valid_reg;
    assign pix_out_sof = out_sof_reg;
    assign corrected_level = out_level_reg;

    // Register writes
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            correction_enable_reg <= FFC_EN_RST;
            map_slot_select_reg <= FFC_SLOT_RST;
            boot_slot_select_reg <= FFC_BOOT_RST;
            ref_level_reg <= PIX_W'(FFC_REF_RST);
        end
        else if (ce && reg_wr)
        begin
            case (reg_addr)
                FFC_OFS_CTRL: correction_enable_reg <= reg_wdata[FFC_CTRL_EN_BIT];
                FFC_OFS_SLOT: map_slot_select_reg <= reg_wdata[FFC_SLOT_W-1:0];
                FFC_OFS_BOOT: boot_slot_select_reg <= reg_wdata[FFC_SLOT_W-1:0];
                FFC_OFS_REF: ref_level_reg <= reg_wdata[PIX_W-1:0];
                default: ;
            endcase
        end
    end

    // Register reads
    always_comb
    begin
        rdata_next = '0;
        case (reg_addr)
            FFC_OFS_CTRL: rdata_next[FFC_CTRL_EN_BIT] = correction_enable_reg;
            FFC_OFS_SLOT: rdata_next[FFC_SLOT_W-1:0] = map_slot_select_reg;
            FFC_OFS_BOOT: rdata_next[FFC_SLOT_W-1:0] = boot_slot_select_reg;
            FFC_OFS_REF: rdata_next[PIX_W-1:0] = ref_level_reg;
            FFC_OFS_STAT:
            begin
                rdata_next[FFC_STAT_BUSY_BIT] = (state_reg != ST_IDLE);
                rdata_next[FFC_STAT_STATE_LSB +: 3] = state_reg;
                rdata_next[FFC_STAT_MAPOK_BIT] = map_ok_reg;
            end
            default: rdata_next = '0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_reg <= '0;
        end
        else if (ce)
        begin
            rdata_reg <= reg_rd ? rdata_next : '0;
        end
    end

    // Commands only while idle; generate, then store, then recall
    assign cmd_wr = ce && reg_wr && (reg_addr == FFC_OFS_CMD) && (state_reg == ST_IDLE);
    assign map_generate_cmd = cmd_wr && reg_wdata[FFC_CMD_GEN_BIT];
    assign map_store_cmd = cmd_wr && !reg_wdata[FFC_CMD_GEN_BIT] && reg_wdata[FFC_CMD_STORE_BIT];
    assign map_recall_cmd = cmd_wr && !reg_wdata[FFC_CMD_GEN_BIT] && !reg_wdata[FFC_CMD_STORE_BIT]
                            && reg_wdata[FFC_CMD_RECALL_BIT];

    assign src_slot = (state_reg == ST_BOOT) ? boot_slot_select_reg : op_slot_reg;
    assign copy_last = (copy_idx_reg == IDX_W'(MAP_N - 1));

    // Sequencer
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= ST_BOOT;
            op_slot_reg <= FFC_SLOT_RST;
            copy_idx_reg <= '0;
            map_ok_reg <= 1'b0;
        end
        else if (ce)
        begin
            unique case (state_reg)
                ST_BOOT, ST_LOAD, ST_STORE:
                begin
                    copy_idx_reg <= copy_last ? '0 : IDX_W'(copy_idx_reg + IDX_W'(1));
                    if (copy_last)
                    begin
                        state_reg <= ST_IDLE;
                        if (state_reg != ST_STORE)
                        begin
                            map_ok_reg <= 1'b1;
                        end
                    end
                end
                ST_IDLE:
                begin
                    if (map_generate_cmd)
                    begin
                        state_reg <= ST_GWAIT;
                    end
                    else if (map_store_cmd)
                    begin
                        op_slot_reg <= map_slot_select_reg;
                        state_reg <= ST_STORE;
                    end
                    else if (map_recall_cmd)
                    begin
                        op_slot_reg <= map_slot_select_reg;
                        state_reg <= ST_LOAD;
                    end
                end
                ST_GWAIT:
                begin
                    if (acc && pix_in_sof)
                    begin
                        state_reg <= ST_GRUN;
                    end
                end
                ST_GRUN:
                begin
                    if (acc && frame_last)
                    begin
                        state_reg <= ST_IDLE;
                        map_ok_reg <= 1'b1;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Working map, lost on reset
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < MAP_N; i++)
            begin
                work_map[i] <= '0;
            end
        end
        else if (ce)
        begin
            if (state_reg == ST_BOOT || state_reg == ST_LOAD)
            begin
                work_map[copy_idx_reg] <= nv_map[src_slot][copy_idx_reg];
            end
            else if (gen_wr)
            begin
                work_map[map_idx(cx, cy)] <= original_level;
            end
        end
    end

    // Retained slots, no reset
    always_ff @(posedge clk_sys)
    begin
        if (ce && state_reg == ST_STORE)
        begin
            nv_map[op_slot_reg][copy_idx_reg] <= work_map[copy_idx_reg];
        end
    end

    // Pixel position
    assign acc = pix_in_valid && pix_in_ready_reg;
    assign cur_x = pix_in_sof ? '0 : x_reg;
    assign cur_y = pix_in_sof ? '0 : y_reg;
    assign frame_last = (cur_x == XW'(IMG_W - 1)) && (cur_y == YW'(IMG_H - 1));
    assign on_grid = (cur_x[STEP_LOG-1:0] == '0) && (cur_y[STEP_LOG-1:0] == '0);
    assign gen_wr = acc && on_grid && (state_reg == ST_GRUN || (state_reg == ST_GWAIT && pix_in_sof));

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            x_reg <= '0;
            y_reg <= '0;
        end
        else if (ce && acc)
        begin
            if (cur_x == XW'(IMG_W - 1))
            begin
                x_reg <= '0;
                y_reg <= (cur_y == YW'(IMG_H - 1)) ? '0 : YW'(cur_y + YW'(1));
            end
            else
            begin
                x_reg <= XW'(cur_x + XW'(1));
                y_reg <= cur_y;
            end
        end
    end

    // Bilinear enlargement of the reduced map, edges clamped
    always_comb
    begin
        cx = int'(cur_x) >> STEP_LOG;
        cy = int'(cur_y) >> STEP_LOG;
        cx1 = (cx == MAP_W - 1) ? cx : cx + 1;
        cy1 = (cy == MAP_H - 1) ? cy : cy + 1;
        row0 = lerp(work_map[map_idx(cx, cy)], work_map[map_idx(cx1, cy)], cur_x[STEP_LOG-1:0]);
        row1 = lerp(work_map[map_idx(cx, cy1)], work_map[map_idx(cx1, cy1)], cur_x[STEP_LOG-1:0]);
        interp = lerp(row0, row1, cur_y[STEP_LOG-1:0]);
    end

    // Stage one
    assign adv = fifo_in_ready || !div_valid;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_valid_reg <= 1'b0;
            s1_sof_reg <= 1'b0;
            s1_level_reg <= '0;
            s1_map_reg <= '0;
            s1_bypass_reg <= 1'b1;
        end
        else if (ce && adv)
        begin
            s1_valid_reg <= acc;
            s1_sof_reg <= pix_in_sof;
            s1_level_reg <= original_level;
            s1_map_reg <= interp;
            s1_bypass_reg <= !correction_enable_reg;
        end
    end

    ffc_div #(
        .PIX_W(PIX_W)
    ) u_div (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .en(adv),
        .in_valid(s1_valid_reg),
        .in_sof(s1_sof_reg),
        .in_level(s1_level_reg),
        .in_map(s1_map_reg),
        .in_ref(ref_level_reg),
        .in_bypass(s1_bypass_reg),
        .out_valid(div_valid),
        .out_sof(div_sof),
        .out_level(div_level)
    );

    ffc_fifo #(
        .W(DW),
        .DEPTH(FIFO_DEPTH),
        .LVL_W(LVL_W)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .in_valid(div_valid),
        .in_ready(fifo_in_ready),
        .in_data({div_sof, div_level}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    // Ready only while all words in flight fit the buffer
    assign occupancy = CNT_W'(fifo_level) + CNT_W'(s1_valid_reg) + CNT_W'(div_valid) + CNT_W'(acc);

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pix_in_ready_reg <= 1'b0;
        end
        else if (ce)
        begin
            pix_in_ready_reg <= (occupancy < CNT_W'(FIFO_DEPTH));
        end
    end

    // Output register
    assign fifo_out_ready = !out_valid_reg || pix_out_ready;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            out_valid_reg <= 1'b0;
            out_sof_reg <= 1'b0;
            out_level_reg <= '0;
        end
        else if (ce && fifo_out_ready)
        begin
            out_valid_reg <= fifo_out_valid;
            out_sof_reg <= fifo_out_data[PIX_W];
            out_level_reg <= fifo_out_data[PIX_W-1:0];
        end
    end

endmodule : ffc_top

`default_nettype wire

/* File: ffc_top_chk.sv */
// Port property checker for the flat field correction unit
`default_nettype none

module ffc_top_chk #(
    parameter int PIX_W = ffc_pkg::FFC_PIX_W
) (
    input wire logic clk_sys, // Clock
    input wire logic rstn, // Reset
    input wire logic ce, // Enable
    input wire logic [ffc_pkg::FFC_ADDR_W-1:0] reg_addr, // Address
    input wire logic [ffc_pkg::FFC_DATA_W-1:0] reg_wdata, // Wdata
    input wire logic reg_wr, // Write
    input wire logic reg_rd, // Read
    input wire logic [ffc_pkg::FFC_DATA_W-1:0] reg_rdata, // Rdata
    input wire logic pix_in_valid, // In valid
    input wire logic pix_in_ready, // In ready
    input wire logic pix_in_sof, // In sof
    input wire logic [PIX_W-1:0] original_level, // In level
    input wire logic pix_out_valid, // Out valid
    input wire logic pix_out_ready, // Out ready
    input wire logic pix_out_sof, // Out sof
    input wire logic [PIX_W-1:0] corrected_level // Out level
);
    timeunit 1ns;
    timeprecision 1ps;
    import ffc_pkg::*;
    logic en_q;
    logic [11:0] ref_q;
    logic [6:0] cyc;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Shadows of fields, edges since reset
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            en_q <= FFC_EN_RST;
            ref_q <= 12'(FFC_REF_RST);
            cyc <= 7'h0;
        end
        else if (ce)
        begin
            if (reg_wr && reg_addr == FFC_OFS_CTRL)
                en_q <= reg_wdata[0];
            if (reg_wr && reg_addr == FFC_OFS_REF)
                ref_q <= reg_wdata[11:0];
            if (cyc != 7'h7f)
                cyc <= cyc + 7'h1;
        end
    end
    sequence s_rd(logic [7:0] a);
        ce && reg_rd && reg_addr == a;
    endsequence
    a_rdata_idle_zero: assert property (ce && !reg_rd |=> reg_rdata == '0) else $error("read data not cleared");
    a_cmd_reads_zero: assert property (s_rd(FFC_OFS_CMD) |=> reg_rdata == '0) else $error("command reads nonzero");
    a_unmapped_zero: assert property (ce && reg_rd && reg_addr > 8'h14 |=> reg_rdata == '0)
        else $error("unmapped read nonzero");
    a_stat_upper_zero: assert property (s_rd(FFC_OFS_STAT) |=> reg_rdata[31:5] == '0) else $error("status high bits");
    a_ctrl_readback: assert property (s_rd(FFC_OFS_CTRL) |=> reg_rdata == {31'h0, en_q}) else $error("enable readback");
    a_ref_readback: assert property (s_rd(FFC_OFS_REF) |=> reg_rdata == {20'h0, ref_q}) else $error("reference readback");
    a_boot_busy: assert property (s_rd(FFC_OFS_STAT) |=> reg_rdata[0] || cyc > 7'd60) else $error("boot copy not busy");
    a_out_hold: assert property (pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(corrected_level)
        && $stable(pix_out_sof)) else $error("output pixel not held");
endmodule : ffc_top_chk

bind ffc_top ffc_top_chk #(.PIX_W(PIX_W)) u_chk (.*);

`default_nettype wire

/* File: test_flat_field_correction_unit.sv */
// Self-checking bench for the flat field correction unit
`default_nettype none

module test_flat_field_correction_unit;
    timeunit 1ns;
    timeprecision 1ps;
    import ffc_pkg::*;
    logic clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, exp_en = 1'b0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
    logic pix_in_valid, pix_in_ready, pix_in_sof, pix_out_valid, pix_out_ready, pix_out_sof;
    logic [11:0] original_level, corrected_level, base = 12'h0;
    logic [12:0] count = 13'h0;
    int num_errors = 0, n_compared = 0, k = 0, exp_map = 0, exp_base = 0;

    ffc_top dut (.*);
    ffc_pix_partner u_partner (.*);

    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic summarize();
        if (num_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    function automatic logic [11:0] expect_level(input int lvl);
        int q;
        if (!exp_en)
            return 12'(lvl);
        q = (exp_map == 0) ? 4095 : lvl * FFC_REF_RST / exp_map;
        return (q > 4095) ? 12'hfff : 12'(q);
    endfunction : expect_level

    always @(posedge clk_sys)
    begin
        if (rstn && pix_out_valid && pix_out_ready)
        begin
            check(32'(corrected_level), 32'(expect_level(exp_base + k % 8)));
            check(32'(pix_out_sof), 32'(k == 0));
            k++;
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        v = reg_rdata;
    endtask : rd

    task automatic wait_idle();
        v = 32'h1;
        for (int i = 0; i < 40 && v[0] !== 1'b0; i++)
            rd(FFC_OFS_STAT);
        check(v & 32'h1, 32'h0);
    endtask : wait_idle

    task automatic do_reset();
        rstn <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        exp_en = 1'b0;
        rd(FFC_OFS_STAT);
        check(v & 32'h1, 32'h1);
        wait_idle();
    endtask : do_reset

    task automatic frame(input int b, input int n);
        @(posedge clk_sys);
        exp_base = b;
        k = 0;
        base <= 12'(b);
        count <= 13'(n);
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        for (int i = 0; i < 20000 && k < n; i++)
            @(posedge clk_sys);
        check(32'(k), 32'(n));
    endtask : frame

    task automatic slot_cmd(input logic [3:0] s, input logic [31:0] c);
        wr(FFC_OFS_SLOT, {28'h0, s});
        wr(FFC_OFS_CMD, c);
        wait_idle();
    endtask : slot_cmd

    task automatic gen(input int b);
        wr(FFC_OFS_CTRL, 32'h0);
        exp_en = 1'b0;
        wr(FFC_OFS_CMD, 32'h1);
        rd(FFC_OFS_STAT);
        check(v & 32'he, 32'h8);
        frame(b, 4096);
        wait_idle();
    endtask : gen

    task automatic use_map(input int m);
        wr(FFC_OFS_CTRL, 32'h1);
        exp_en = 1'b1;
        exp_map = m;
        rd(FFC_OFS_CTRL);
        check(v, 32'h1);
    endtask : use_map

    initial
    begin
        do_reset();
        rd(FFC_OFS_REF);
        check(v, 32'h800);
        rd(8'h18);
        check(v, 32'h0);
        rd(FFC_OFS_CMD);
        check(v, 32'h0);
        wr(FFC_OFS_BOOT, 32'hf);
        rd(FFC_OFS_BOOT);
        check(v, 32'hf);
        wr(FFC_OFS_BOOT, 32'h0);
        frame(100, 20);
        gen(1024);
        use_map(1024);
        frame(2044, 16);
        slot_cmd(4'h0, 32'h2);
        gen(512);
        slot_cmd(4'hf, 32'h2);
        gen(0);
        use_map(0);
        frame(500, 8);
        do_reset();
        use_map(1024);
        frame(2044, 16);
        gen(256);
        slot_cmd(4'hf, 32'h4);
        use_map(512);
        frame(900, 8);
        summarize();
    end

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        summarize();
    end
endmodule : test_flat_field_correction_unit

`default_nettype wire
